/* pipe_ctl_defs.svh */
`ifndef PIPE_CTL_DEFS_SVH
`define PIPE_CTL_DEFS_SVH

// Width of the branch table index carried with every instruction.
`define PIPE_PC_IDX_W 12
// Two-bit history counter: reset value is weakly not taken.
`define PIPE_BHT_RESET 2'h1
`define PIPE_BHT_MAX 2'h3
`define PIPE_BHT_MIN 2'h0
// Counter bit that gives the predicted direction.
`define PIPE_BHT_DIR_BIT 1
// Bubble between a late-result producer and its consumer, in cycles.
`define PIPE_LATE_BUBBLE 2
// Younger instructions cancelled by a flush, and cycles of a flushing instruction.
`define PIPE_FLUSH_PENALTY 3
`define PIPE_FLUSH_CYCLES 4
// Stage positions in the valid vector.
`define PIPE_STG_F 0
`define PIPE_STG_D 1
`define PIPE_STG_E 2
`define PIPE_STG_M 3
`define PIPE_STG_A 4
`define PIPE_STG_W 5
`define PIPE_NUM_STG 6

`endif

/* pipe_ctl_pkg.sv */
`include "pipe_ctl_defs.svh"

package pipe_ctl_pkg;

  // Exception source reported when a flush is taken in the memory stage.
  typedef enum logic [1:0] {
    EXC_NONE = 2'h0,
    EXC_IRQ = 2'h1,
    EXC_TRAP = 2'h2,
    EXC_UNIMPL = 2'h3
  } exc_cause_t;

  // Decoded class of an instruction, as presented by the fetch unit.
  typedef struct packed {
    logic [4:0] src_a;
    logic [4:0] src_b;
    logic [4:0] dst;
    logic use_a;
    logic use_b;
    logic wr_reg;
    logic is_load;
    logic is_store;
    logic is_shift;
    logic is_mul;
    logic is_div;
    logic is_rdctl;
    logic is_custom_mc;
    logic is_branch;
    logic flushes;
    logic is_trap;
    logic is_unimpl;
    logic [`PIPE_PC_IDX_W-1:0] pc_idx;
  } instr_info_t;

  // Contents of one pipeline stage.
  typedef struct packed {
    logic valid;
    logic pred;
    instr_info_t info;
  } stage_t;

  // Branch outcome that trains the history table.
  typedef struct packed {
    logic en;
    logic taken;
    logic [`PIPE_PC_IDX_W-1:0] idx;
  } bht_upd_t;

endpackage

/* branch_history_table.sv */
`timescale 1ns/1ps
`include "pipe_ctl_defs.svh"

module branch_history_table #(
  parameter int IDX_W = 8
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [IDX_W-1:0] i_rd_idx,
  output logic o_rd_taken,
  input wire pipe_ctl_pkg::bht_upd_t i_upd
);

  localparam int ENTRIES = 1 << IDX_W;

  initial begin
    if (IDX_W < 1 || IDX_W > `PIPE_PC_IDX_W) begin
      $error("branch_history_table: IDX_W out of range");
    end
  end

  logic [1:0] ctr_ff [ENTRIES];
  logic [IDX_W-1:0] upd_idx;
  logic [1:0] cur;
  logic [1:0] nxt_ctr;

  assign upd_idx = i_upd.idx[IDX_W-1:0];
  assign cur = ctr_ff[upd_idx];

  // Saturating count toward the observed outcome.
  always_comb begin
    nxt_ctr = cur;
    if (i_upd.taken && cur != `PIPE_BHT_MAX) begin // RL3
      nxt_ctr = cur + 2'h1;
    end else if (!i_upd.taken && cur != `PIPE_BHT_MIN) begin
      nxt_ctr = cur - 2'h1;
    end
  end

  // Every entry starts weakly not taken so cold branches fall through cheaply.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int k = 0; k < ENTRIES; k++) begin
        ctr_ff[k] <= `PIPE_BHT_RESET;
      end
    end else if (i_upd.en) begin
      ctr_ff[upd_idx] <= nxt_ctr; // RL3
    end
  end

  // Read is combinational so the prediction travels with the fetched word.
  assign o_rd_taken = ctr_ff[i_rd_idx][`PIPE_BHT_DIR_BIT]; // RL3

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  bht_saturate_a: assert property ( // RL3
    (i_upd.en && i_upd.taken && cur == `PIPE_BHT_MAX)
      |=> (ctr_ff[$past(upd_idx)] == `PIPE_BHT_MAX))
    else $error("History counter wrapped past its maximum.");

endmodule

/* six_stage_pipeline_control.sv */
`timescale 1ns/1ps
`include "pipe_ctl_defs.svh"

// Notes on behaviour
// RL1 - One dispatch and one retire per cycle.
// RL2 - Dispatch and retire strictly in program order.
// RL3 - Predict branches with two-bit history counters.
// RL4 - Stalled stage and earlier stages hold contents.
// RL5 - No catching up into empty stages.
// RL6 - Only align and decode stages raise stalls.
// RL7 - Align stalls on pending data bus transfers.
// RL8 - Align stalls on busy multi-cycle shifter.
// RL9 - Align stalls on busy optional divider.
// RL10 - Align stalls while custom unit asserts stall.
// RL11 - Decode stalls on early use, unless flushing.
// RL12 - Loads, shifts, rdctl, mul, div, custom are late.
// RL13 - Two-cycle bubble before a late result consumer.
// RL14 - Flush cancels three younger, four cycles total.
// RL15 - Bus instructions wait for one write, one read.
// RL16 - Branch costs: taken 2, not 1, miss 4.
// RL17 - Traps, returns, flushp, wrctl, unimplemented flush.
// RL18 - Loads: one cycle without transfer, late result.
// RL19 - Stores and line flushes: one cycle without transfer.
// RL20 - Shift cycles follow multiplier option, late result.
// RL21 - Exceptions: interrupts, traps, unimplemented instructions.
// RL22 - Stall only on dependent use; independents flow.
// RL23 - Cancelled instructions are invalid, without side effects.
module six_stage_pipeline_control #(
  parameter int IDX_W = 8,
  parameter bit HAS_HW_MUL = 1'b1,
  parameter bit HAS_HW_DIV = 1'b1,
  parameter bit HAS_CUSTOM_MC = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_fetch_valid,
  input wire pipe_ctl_pkg::instr_info_t i_fetch_info,
  output logic o_fetch_ready,
  input wire logic i_m_taken,
  input wire logic i_irq,
  input wire logic i_dbus_busy,
  input wire logic i_shift_busy,
  input wire logic i_div_busy,
  input wire logic i_ci_stall,
  output logic [`PIPE_NUM_STG-1:0] o_stage_valid,
  output logic o_retire,
  output pipe_ctl_pkg::instr_info_t o_retire_info,
  output logic o_stall_a,
  output logic o_stall_d,
  output logic o_flush,
  output pipe_ctl_pkg::exc_cause_t o_exc_cause,
  output logic o_redirect,
  output logic [`PIPE_PC_IDX_W-1:0] o_redirect_idx
);

  initial begin
    if (IDX_W < 1 || IDX_W > `PIPE_PC_IDX_W) begin
      $error("six_stage_pipeline_control: IDX_W out of range");
    end
  end

  localparam pipe_ctl_pkg::stage_t BUBBLE = '0;

  pipe_ctl_pkg::stage_t f_ff, d_ff, e_ff, m_ff, a_ff, w_ff;
  pipe_ctl_pkg::bht_upd_t bht_upd;
  logic fetch_pred;
  logic stall_a, stall_d, hold_d;
  logic dep_e, dep_m;
  logic mispredict, irq_take, m_flush_req, m_flush, redirect;
  logic flush_ff, stall_a_ff, stall_d_ff, redirect_ff;
  logic [`PIPE_PC_IDX_W-1:0] redirect_idx_ff;
  pipe_ctl_pkg::exc_cause_t exc_ff, nxt_exc;

  // Classes whose result is produced only at the end of the align stage.
  function automatic logic is_late(input pipe_ctl_pkg::instr_info_t x);
    is_late = x.is_load || x.is_shift || x.is_rdctl // RL12 RL18
      || (x.is_mul && HAS_HW_MUL) || (x.is_div && HAS_HW_DIV)
      || (x.is_custom_mc && HAS_CUSTOM_MC);
  endfunction

  // A consumer depends on a late producer when a used source names its target.
  function automatic logic reads_result(input pipe_ctl_pkg::stage_t c,
                                        input pipe_ctl_pkg::stage_t p);
    reads_result = c.valid && p.valid && p.info.wr_reg && is_late(p.info)
      && ((c.info.use_a && c.info.src_a == p.info.dst)
      || (c.info.use_b && c.info.src_b == p.info.dst));
  endfunction

  branch_history_table #(
    .IDX_W(IDX_W)
  ) u_bht (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_rd_idx(i_fetch_info.pc_idx[IDX_W-1:0]),
    .o_rd_taken(fetch_pred),
    .i_upd(bht_upd)
  );

  // Align stage stall sources; nothing in any other stage may stall it.
  always_comb begin
    stall_a = 1'b0;
    if (a_ff.valid) begin
      stall_a = ((a_ff.info.is_load || a_ff.info.is_store) && i_dbus_busy) // RL7 RL15 RL19
        || (a_ff.info.is_shift && !HAS_HW_MUL && i_shift_busy) // RL8 RL20
        || (a_ff.info.is_div && HAS_HW_DIV && i_div_busy) // RL9
        || (a_ff.info.is_custom_mc && HAS_CUSTOM_MC && i_ci_stall); // RL10
    end
  end

  // Memory-stage flush sources. Exceptions take priority over a mispredict.
  assign mispredict = m_ff.valid && m_ff.info.is_branch && (m_ff.pred != i_m_taken); // RL16
  assign irq_take = m_ff.valid && i_irq; // RL21
  assign m_flush_req = m_ff.valid && (m_ff.info.flushes || m_ff.info.is_trap // RL17
    || m_ff.info.is_unimpl || mispredict || irq_take);
  // A flush waits for the align stage so the flushing instruction moves on.
  assign m_flush = m_flush_req && !stall_a; // RL14

  // Producer in execute needs two bubbles, in memory one, in align none.
  assign dep_e = reads_result(d_ff, e_ff); // RL13 RL22
  assign dep_m = reads_result(d_ff, m_ff); // RL13 RL22
  assign stall_d = (dep_e || dep_m) && !m_flush_req; // RL11 RL6
  assign hold_d = stall_a || stall_d; // RL4

  // Predicted-taken branch in decode drops the fall-through word: one bubble.
  assign redirect = d_ff.valid && d_ff.info.is_branch && d_ff.pred
    && !hold_d && !m_flush; // RL16

  // Fetch advances only while neither stall holds the front end.
  assign o_fetch_ready = !hold_d; // RL1

  always_comb begin
    nxt_exc = pipe_ctl_pkg::EXC_NONE;
    if (irq_take) begin
      nxt_exc = pipe_ctl_pkg::EXC_IRQ; // RL21
    end else if (m_ff.info.is_trap) begin
      nxt_exc = pipe_ctl_pkg::EXC_TRAP; // RL21
    end else if (m_ff.info.is_unimpl) begin
      nxt_exc = pipe_ctl_pkg::EXC_UNIMPL; // RL21
    end
  end

  // Train the history table once, when a branch leaves the memory stage.
  always_comb begin
    bht_upd.en = m_ff.valid && m_ff.info.is_branch && !stall_a; // RL3
    bht_upd.taken = i_m_taken;
    bht_upd.idx = m_ff.info.pc_idx;
  end

  // Fetch slot: loads the next word with its prediction, or a bubble.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      f_ff <= BUBBLE;
    end else if (!hold_d) begin // RL4 RL5
      if (m_flush || redirect || !i_fetch_valid) begin
        f_ff <= BUBBLE; // RL23
      end else begin
        f_ff.valid <= 1'b1; // RL1 RL2
        f_ff.pred <= fetch_pred; // RL3
        f_ff.info <= i_fetch_info;
      end
    end
  end

  // Decode slot: holds on either stall, killed by flush or redirect.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      d_ff <= BUBBLE;
    end else if (!hold_d) begin // RL4 RL5
      d_ff <= (m_flush || redirect) ? BUBBLE : f_ff; // RL14 RL23
    end
  end

  // Execute slot: a decode stall inserts a bubble here, never a collapse.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      e_ff <= BUBBLE;
    end else if (!stall_a) begin // RL4
      e_ff <= (stall_d || m_flush) ? BUBBLE : d_ff; // RL13 RL14 RL23
    end
  end

  // Memory slot: an executing younger instruction is cancelled by a flush.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      m_ff <= BUBBLE;
    end else if (!stall_a) begin // RL4
      m_ff <= m_flush ? BUBBLE : e_ff; // RL14 RL23
    end
  end

  // Align slot takes the flushing instruction itself so it still retires.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      a_ff <= BUBBLE;
    end else if (!stall_a) begin // RL4
      a_ff <= m_ff; // RL2
    end
  end

  // Writeback: one retirement per cycle at most; an align stall sends a bubble.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      w_ff <= BUBBLE;
    end else begin
      w_ff <= stall_a ? BUBBLE : a_ff; // RL1 RL2 RL5
    end
  end

  // Registered status seen by the datapath and by debug logic.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stall_a_ff <= 1'b0;
      stall_d_ff <= 1'b0;
      flush_ff <= 1'b0;
      exc_ff <= pipe_ctl_pkg::EXC_NONE;
    end else begin
      stall_a_ff <= stall_a;
      stall_d_ff <= stall_d;
      flush_ff <= m_flush; // RL14
      exc_ff <= m_flush ? nxt_exc : pipe_ctl_pkg::EXC_NONE;
    end
  end

  // Redirect request for the fetch unit, one cycle per predicted-taken branch.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      redirect_ff <= 1'b0;
      redirect_idx_ff <= '0;
    end else begin
      redirect_ff <= redirect; // RL16
      redirect_idx_ff <= redirect ? d_ff.info.pc_idx : redirect_idx_ff;
    end
  end

  assign o_stage_valid = {w_ff.valid, a_ff.valid, m_ff.valid,
                          e_ff.valid, d_ff.valid, f_ff.valid};
  assign o_retire = w_ff.valid;
  assign o_retire_info = w_ff.info;
  assign o_stall_a = stall_a_ff;
  assign o_stall_d = stall_d_ff;
  assign o_flush = flush_ff;
  assign o_exc_cause = exc_ff;
  assign o_redirect = redirect_ff;
  assign o_redirect_idx = redirect_idx_ff;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  front_hold_a: assert property ( // RL4
    stall_a |=> ($stable(f_ff) && $stable(d_ff) && $stable(e_ff)
      && $stable(m_ff) && $stable(a_ff)))
    else $error("A stage moved during an align stall.");

  no_catchup_a: assert property ( // RL5
    (stall_d && !stall_a) |=> ($stable(d_ff) && $stable(f_ff) && !e_ff.valid))
    else $error("Upstream stage advanced during a decode stall.");

  in_order_a: assert property ( // RL2
    !stall_a |=> (w_ff == $past(a_ff) && a_ff == $past(m_ff)))
    else $error("Retirement left program order.");

  mem_wait_a: assert property ( // RL7
    (a_ff.valid && a_ff.info.is_load && i_dbus_busy) |-> (stall_a ##1 o_stall_a))
    else $error("Load in align did not wait for the data bus.");

  shift_wait_a: assert property ( // RL8
    (a_ff.valid && a_ff.info.is_shift && i_shift_busy && !HAS_HW_MUL) |-> stall_a)
    else $error("Busy shifter did not stall align.");

  late_dep_a: assert property ( // RL11
    (dep_e && !m_flush_req && !stall_a) |=> !e_ff.valid)
    else $error("Dependent entered execute too early.");

  two_bubble_a: assert property ( // RL13
    (dep_e && !m_flush_req && !stall_a) ##1 (!m_flush_req && !stall_a)
      |=> (!e_ff.valid && !$past(e_ff.valid)))
    else $error("Late result bubble shorter than two cycles.");

  flush_kill_a: assert property ( // RL14
    m_flush |=> (!f_ff.valid && !d_ff.valid && !e_ff.valid && !m_ff.valid
      && a_ff.valid && flush_ff))
    else $error("Flush did not cancel the three younger slots.");

  redirect_bubble_a: assert property ( // RL16
    redirect |=> (!d_ff.valid && redirect_ff))
    else $error("Predicted taken branch did not drop its fall-through.");

  div_wait_a: assert property ( // RL9
    (a_ff.valid && a_ff.info.is_div && i_div_busy && HAS_HW_DIV) |=> $stable(a_ff))
    else $error("Divide left align while still computing.");

endmodule

/* datapath_units_model.sv */
`timescale 1ns/1ps

// Stand-in for the multi-cycle units and the data bus port beside the pipeline.
// A kick loads a busy span, so a unit can answer at once (short span) or slowly (long span).
module datapath_units_model (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [3:0] i_kick,
  input wire logic [5:0] i_len,
  output logic o_dbus_busy,
  output logic o_shift_busy,
  output logic o_div_busy,
  output logic o_ci_stall
);
  logic [5:0] cnt_ff [4];

  // Each unit runs its own count down; a unit is never busy without a kick.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int k = 0; k < 4; k++) begin
        cnt_ff[k] <= 6'h00;
      end
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (i_kick[k]) begin
          cnt_ff[k] <= i_len;
        end else if (cnt_ff[k] != 6'h00) begin
          cnt_ff[k] <= cnt_ff[k] - 6'h01;
        end
      end
    end
  end

  // Busy levels follow the counts directly, with no gap after the kick.
  assign o_dbus_busy = (cnt_ff[0] != 6'h00);
  assign o_shift_busy = (cnt_ff[1] != 6'h00);
  assign o_div_busy = (cnt_ff[2] != 6'h00);
  assign o_ci_stall = (cnt_ff[3] != 6'h00);
endmodule

/* six_stage_pipeline_control_tb_top.sv */
`timescale 1ns/1ps
`include "pipe_ctl_defs.svh"

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

// Random instruction streams with hand-picked hazard, stall, flush and branch cases.
module six_stage_pipeline_control_tb_top;
  logic i_clk, i_resetn, fv, m_taken, irq;
  pipe_ctl_pkg::instr_info_t finfo, retire_info;
  logic [3:0] kick;
  logic [5:0] len, stage_valid, sv;
  logic dbus_busy, shift_busy, div_busy, ci_stall;
  logic fetch_ready, retire, stall_a, stall_d, flush, redirect;
  pipe_ctl_pkg::exc_cause_t exc_cause, cause;
  logic [11:0] redirect_idx, rd_idx;
  int fails, checks, n_sd, n_sa, n_fl, n_rd;
  integer seed;
  logic [11:0] ret_q[$], exp_q[$];
  int ucls[6] = '{0, 7, 4, 5, 1, 6};
  logic [3:0] uk[6] = '{4'h1, 4'h1, 4'h4, 4'h8, 4'h2, 4'h1};
  bit uexp[6] = '{1, 1, 1, 1, 1, 0};
  int fk[5] = '{8, 9, 10, 6, 11};
  pipe_ctl_pkg::exc_cause_t fc[5] = '{pipe_ctl_pkg::EXC_NONE, pipe_ctl_pkg::EXC_TRAP,
    pipe_ctl_pkg::EXC_UNIMPL, pipe_ctl_pkg::EXC_IRQ, pipe_ctl_pkg::EXC_NONE};

  // Built without a hardware multiplier, so the multi-cycle shifter can stall align.
  six_stage_pipeline_control #(.HAS_HW_MUL(1'b0)) DUT (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_fetch_valid(fv), .i_fetch_info(finfo),
    .o_fetch_ready(fetch_ready), .i_m_taken(m_taken), .i_irq(irq),
    .i_dbus_busy(dbus_busy), .i_shift_busy(shift_busy), .i_div_busy(div_busy),
    .i_ci_stall(ci_stall), .o_stage_valid(stage_valid), .o_retire(retire),
    .o_retire_info(retire_info), .o_stall_a(stall_a), .o_stall_d(stall_d),
    .o_flush(flush), .o_exc_cause(exc_cause), .o_redirect(redirect),
    .o_redirect_idx(redirect_idx));

  datapath_units_model units (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_kick(kick), .i_len(len),
    .o_dbus_busy(dbus_busy), .o_shift_busy(shift_busy), .o_div_busy(div_busy),
    .o_ci_stall(ci_stall));

  // The clock runs at 50 MHz.
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // Outputs are sampled mid-cycle, where every registered output has settled.
  always @(negedge i_clk) begin
    if (retire === 1'b1) ret_q.push_back(retire_info.pc_idx);
    if (stall_d === 1'b1) n_sd++;
    if (stall_a === 1'b1) n_sa++;
    if (flush === 1'b1) begin
      n_fl++;
      cause = exc_cause;
      sv = stage_valid;
    end
    if (redirect === 1'b1) begin
      n_rd++;
      rd_idx = redirect_idx;
    end
  end

  function automatic int rnd(input int n);
    rnd = $unsigned($random(seed)) % n;
  endfunction

  // Builds one decoded word; class 6 is a plain ALU operation.
  function automatic pipe_ctl_pkg::instr_info_t mk(input int k, input int d, input int s,
                                                   input logic [11:0] pc);
    pipe_ctl_pkg::instr_info_t t;
    t = '0;
    t.dst = 5'(d);
    t.wr_reg = (d != 0);
    t.src_a = 5'(s);
    t.use_a = (s != 0);
    t.pc_idx = pc;
    case (k)
      0: t.is_load = 1'b1;
      1: t.is_shift = 1'b1;
      2: t.is_rdctl = 1'b1;
      3: t.is_mul = 1'b1;
      4: t.is_div = 1'b1;
      5: t.is_custom_mc = 1'b1;
      7: t.is_store = 1'b1;
      8: t.flushes = 1'b1;
      9: t.is_trap = 1'b1;
      10: t.is_unimpl = 1'b1;
      11: t.is_branch = 1'b1;
      default: ;
    endcase
    return t;
  endfunction

  // Offers a word and holds it until an edge at which the pipeline is ready.
  task automatic go(input pipe_ctl_pkg::instr_info_t x, input logic [3:0] k);
    logic rdy;
    fv <= 1'b1;
    finfo <= x;
    kick <= k;
    exp_q.push_back(x.pc_idx);
    rdy = 1'b0;
    while (rdy !== 1'b1) begin
      @(negedge i_clk);
      rdy = fetch_ready;
      @(posedge i_clk);
    end
  endtask

  task automatic idle(input int n);
    fv <= 1'b0;
    kick <= 4'h0;
    repeat (n) @(posedge i_clk);
  endtask

  task automatic clr();
    ret_q.delete();
    exp_q.delete();
    n_sd = 0;
    n_sa = 0;
    n_fl = 0;
    n_rd = 0;
    cause = pipe_ctl_pkg::EXC_NONE;
    sv = 6'h00;
    rd_idx = 12'h000;
  endtask

  task automatic chk_q();
    `CHK(ret_q.size(), exp_q.size())
    foreach (exp_q[i]) `CHK(ret_q[i], exp_q[i])
  endtask

  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the roughly one thousand cycles the tests need.
  initial begin
    repeat (6000) @(posedge i_clk);
    fails++;
    print_verdict();
  end

  initial begin
    int n, r;
    logic [1:0] bc;
    logic act, pred;
    seed = 32'h3D75;
    i_resetn = 1'b0;
    fv = 1'b0;
    finfo = '0;
    m_taken = 1'b0;
    irq = 1'b0;
    kick = 4'h0;
    len = 6'h00;
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(negedge i_clk);
    `CHK(stage_valid, 6'h00)
    `CHK(exc_cause, pipe_ctl_pkg::EXC_NONE)
    @(posedge i_clk);
    // Random streams of mixed classes must all retire, once each and in order.
    for (int t = 0; t < 4; t++) begin
      clr();
      n = 4 + rnd(5);
      for (int i = 0; i < n; i++) go(mk(rnd(7), rnd(32), rnd(32), 12'h100 + 12'(i)), 4'h0);
      idle(24);
      chk_q();
      $display("test stream %0d done", t);
    end
    // Producer, then 0..2 independent words, then a consumer of its result.
    for (int k = 0; k < 7; k++) begin
      for (int g = 0; g < 3; g++) begin
        clr();
        r = 1 + rnd(31);
        go(mk(k, r, 0, 12'h200), 4'h0);
        for (int i = 0; i < g; i++) go(mk(6, 0, 0, 12'h201 + 12'(i)), 4'h0);
        go(mk(6, 0, r, 12'h20F), 4'h0);
        idle(16);
        `CHK(n_sd, (k < 6 && k != 3 && g < 2) ? `PIPE_LATE_BUBBLE - g : 0)
        chk_q();
        $display("test hazard %0d %0d done", k, g);
      end
    end
    // A busy unit holds the align stage only for the class that uses it.
    for (int k = 0; k < 6; k++) begin
      clr();
      n = 5 + rnd(8);
      len <= 6'(n);
      go(mk(ucls[k], 0, 0, 12'h300), uk[k]);
      go(mk(6, 0, 0, 12'h301), 4'h0);
      go(mk(6, 0, 0, 12'h302), 4'h0);
      idle(24);
      `CHK(n_sa, uexp[k] ? n - `PIPE_STG_A : 0)
      chk_q();
      $display("test align %0d done", k);
    end
    // Flushing words, an interrupt and a missed branch each cancel three younger words.
    for (int k = 0; k < 5; k++) begin
      clr();
      m_taken <= (k == 4);
      go(mk(fk[k], 0, 0, 12'h021), 4'h0);
      irq <= (k == 3);
      for (int i = 0; i < `PIPE_FLUSH_PENALTY; i++) go(mk(6, 0, 0, 12'h401 + 12'(i)), 4'h0);
      idle(14);
      irq <= 1'b0;
      `CHK(n_fl, 1)
      `CHK(cause, fc[k])
      `CHK(sv, 6'h10)
      `CHK(ret_q.size(), 1)
      `CHK(ret_q[0], 12'h021)
      $display("test flush %0d done", k);
    end
    // One branch trained by three taken, two not-taken, then random outcomes against a saturating two-bit model.
    bc = 2'h1;
    for (int t = 0; t < 12; t++) begin
      clr();
      act = (t < 3) ? 1'b1 : ((t < 5) ? 1'b0 : 1'(rnd(2)));
      pred = bc[1];
      m_taken <= act;
      go(mk(11, 0, 0, 12'h033), 4'h0);
      go(mk(6, 0, 0, 12'h034), 4'h0);
      idle(14);
      `CHK(n_rd, int'(pred))
      `CHK(n_fl, int'(pred != act))
      `CHK(ret_q.size(), (!pred && !act) ? 2 : 1)
      if (pred) `CHK(rd_idx, 12'h033)
      bc = act ? ((bc == 2'h3) ? bc : bc + 2'h1) : ((bc == 2'h0) ? bc : bc - 2'h1);
      $display("test branch %0d done", t);
    end
    print_verdict();
  end
endmodule
